/* File: logic/dist_mem.sv */
`timescale 1ns/1ps
module dist_mem (
    // clock
    input  wire logic                          clk_sys,
    // write port
    input  wire logic                          we,
    input  wire logic [tile_pkg::MEM_AW-1:0]   waddr,
    input  wire logic [tile_pkg::MEM_DW-1:0]   wdata,
    // read port
    input  wire logic [tile_pkg::MEM_AW-1:0]   raddr,
    output logic      [tile_pkg::MEM_DW-1:0]   rdata_ff
);
    import tile_pkg::*;

    logic [MEM_DW-1:0] mem [MEM_DEPTH];

    always_ff @(posedge clk_sys)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        rdata_ff <= mem[raddr];
    end
endmodule

/* File: logic/logic_tile.sv */
`timescale 1ns/1ps
module logic_tile (
    // clock and reset
    input  wire logic                                   clk_sys,
    input  wire logic                                   rstn,
    // apb slave
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [tile_pkg::ADDR_W-1:0]            paddr,
    input  wire logic [31:0]                            pwdata,
    output logic      [31:0]                            prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    // general routing
    input  wire tile_pkg::slice_in_t [tile_pkg::N_SLICE-1:0] route_in,
    input  wire tile_pkg::pair_ctl_t [tile_pkg::N_PAIR-1:0]  pair_ctl,
    output tile_pkg::slice_out_t     [tile_pkg::N_SLICE-1:0] route_out,
    // carry chain
    input  wire logic                                   carry_chain_in,
    output logic                                        carry_chain_out
);
    import tile_pkg::*;

    // configuration state
    logic [LUT_W-1:0]  lut_ff [N_LUT];
    slice_cfg_t        cfg_ff [N_SLICE];
    logic              run_ff;
    logic              ram_ff;
    logic              pdp_ff;

    // bus state
    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       prdata_ff;

    // slice state
    logic [N_SLICE-1:0][1:0] q_ff;
    logic [N_SLICE-1:0][1:0] f_ff;
    logic [N_PAIR-1:0]       clk_q_ff;
    logic                    cco_ff;

    // combinational
    logic [N_SLICE:0]        chain;
    logic [N_SLICE-1:0]      f0_w;
    logic [N_SLICE-1:0]      f1_w;
    logic [N_SLICE-1:0][1:0] d_w;
    logic [N_SLICE-1:0][1:0] nxt_q;
    logic [N_SLICE-1:0][1:0] init_v;
    logic [N_SLICE-1:0]      act_edge;
    logic [N_PAIR-1:0]       rise;
    logic [N_PAIR-1:0]       fall;

    // memory side
    logic [MEM_AW-1:0]       memory_write_address;
    logic [MEM_DW-1:0]       memory_write_data;
    logic [MEM_AW-1:0]       mem_raddr;
    logic [MEM_DW-1:0]       mem_rdata;
    logic [2*N_SLICE-1:0]    mem_f;
    logic                    fab_we;
    logic                    apb_mem_we;
    logic                    mem_we;
    logic [MEM_AW-1:0]       mem_waddr;
    logic [MEM_DW-1:0]       mem_wdata;

    // bus decode
    logic                    acc;
    logic                    done;
    logic                    wr_ok;
    logic                    hit_lut;
    logic                    hit_cfg;
    logic                    hit_ctrl;
    logic                    hit_stat;
    logic                    hit_mem;
    logic                    locked;
    logic                    err_w;
    logic [31:0]             rd_w;

    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign carry_chain_out = cco_ff;

    // ---------------- register bus ----------------
    assign acc      = psel & penable;
    assign done     = acc & pready_ff;
    assign hit_lut  = paddr[11:5] == OFS_LUT[11:5];
    assign hit_cfg  = paddr[11:4] == OFS_CFG[11:4];
    assign hit_ctrl = paddr[11:2] == OFS_CTRL[11:2];
    assign hit_stat = paddr[11:2] == OFS_STAT[11:2];
    assign hit_mem  = paddr[11:6] == OFS_MEM[11:6];
    // tables and memory image are closed to bus writes once the tile runs
    assign locked   = run_ff & (hit_lut | hit_cfg | hit_mem);

    always_comb
    begin
        err_w = (paddr[1:0] != 2'b00)
              | ~(hit_lut | hit_cfg | hit_ctrl | hit_stat | hit_mem)
              | (pwrite & (locked | hit_stat));
    end

    assign wr_ok = done & pwrite & ~err_w;

    always_comb
    begin
        rd_w = 32'h0000_0000;
        if (hit_lut)
        begin
            rd_w[LUT_W-1:0] = lut_ff[paddr[4:2]];
        end
        else if (hit_cfg)
        begin
            rd_w[CFG_W-1:0] = cfg_ff[paddr[3:2]];
        end
        else if (hit_ctrl)
        begin
            rd_w[CTRL_RUN] = run_ff;
            rd_w[CTRL_RAM] = ram_ff;
            rd_w[CTRL_PDP] = pdp_ff;
        end
        else if (hit_stat)
        begin
            rd_w[2*N_SLICE-1:0]         = q_ff;
            rd_w[4*N_SLICE-1:2*N_SLICE] = f_ff;
            rd_w[STAT_RUN]              = run_ff;
        end
    end

    // one wait state: answer registered in the first access cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            pready_ff  <= acc & ~pready_ff;
            pslverr_ff <= acc & ~pready_ff & err_w;
            if (acc & ~pready_ff & ~pwrite)
            begin
                prdata_ff <= err_w ? 32'h0000_0000 : rd_w;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < N_LUT; i++)
            begin
                lut_ff[i] <= LUT_RST;
            end
        end
        else if (wr_ok && hit_lut)
        begin
            lut_ff[paddr[4:2]] <= pwdata[LUT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < N_SLICE; i++)
            begin
                cfg_ff[i] <= slice_cfg_t'(CFG_RST);
            end
        end
        else if (wr_ok && hit_cfg)
        begin
            cfg_ff[paddr[3:2]] <= slice_cfg_t'(pwdata[CFG_W-1:0]);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            {pdp_ff, ram_ff, run_ff} <= CTRL_RST;
        end
        else if (wr_ok && hit_ctrl)
        begin
            run_ff <= pwdata[CTRL_RUN];
            // mode change only while stopped
            if (!run_ff)
            begin
                ram_ff <= pwdata[CTRL_RAM];
                pdp_ff <= pwdata[CTRL_PDP];
            end
        end
    end

    // ---------------- slices ----------------
    assign chain[0] = carry_chain_in;

    for (genvar s = 0; s < N_SLICE; s++)
    begin : g_slice
        slice_cell u_cell (
            .cfg  (cfg_ff[s]),
            .lut0 (lut_ff[2*s]),
            .lut1 (lut_ff[2*s+1]),
            .sin  (route_in[s]),
            .q    (q_ff[s]),
            .cin  (chain[s]),
            .f0   (f0_w[s]),
            .f1   (f1_w[s]),
            .d    (d_w[s]),
            .cout (chain[s+1])
        );

        assign init_v[s]   = {cfg_ff[s].init1, cfg_ff[s].init0};
        assign act_edge[s] = cfg_ff[s].neg_edge ? fall[s/2] : rise[s/2];
        assign nxt_q[s][0] = cfg_ff[s].src0_direct ? route_in[s].direct[0] : d_w[s][0];
        assign nxt_q[s][1] = cfg_ff[s].src1_direct ? route_in[s].direct[1] : d_w[s][1];
    end

    // slice clocks arrive as routed data, edges found against the last sample
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            clk_q_ff <= '0;
        end
        else
        begin
            for (int p = 0; p < N_PAIR; p++)
            begin
                clk_q_ff[p] <= pair_ctl[p].clk;
            end
        end
    end

    always_comb
    begin
        for (int p = 0; p < N_PAIR; p++)
        begin
            rise[p] = pair_ctl[p].clk & ~clk_q_ff[p];
            fall[p] = ~pair_ctl[p].clk & clk_q_ff[p];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            q_ff <= '0;
        end
        else
        begin
            for (int s = 0; s < N_SLICE; s++)
            begin
                if (!run_ff)
                begin
                    q_ff[s] <= init_v[s];
                end
                else if (cfg_ff[s].async_sr && pair_ctl[s/2].local_set_clear)
                begin
                    q_ff[s] <= init_v[s];
                end
                else if (act_edge[s])
                begin
                    if (pair_ctl[s/2].local_set_clear)
                    begin
                        q_ff[s] <= init_v[s];
                    end
                    else if (pair_ctl[s/2].ce)
                    begin
                        q_ff[s] <= nxt_q[s];
                    end
                end
            end
        end
    end

    // ---------------- distributed memory ----------------
    // slice 2 is used up: its routing supplies address and write enable
    assign memory_write_address = route_in[2].t0;
    assign memory_write_data    = {route_in[1].direct, route_in[0].direct};
    assign mem_raddr            = pdp_ff ? route_in[0].t0 : memory_write_address;
    assign fab_we     = run_ff & ram_ff & act_edge[0] & route_in[2].direct[0];
    assign apb_mem_we = wr_ok & hit_mem;
    assign mem_we     = apb_mem_we | fab_we;
    assign mem_waddr  = apb_mem_we ? paddr[5:2] : memory_write_address;
    assign mem_wdata  = apb_mem_we ? pwdata[MEM_DW-1:0] : memory_write_data;
    assign mem_f      = {{(2*N_SLICE-MEM_DW){1'b0}}, mem_rdata};

    dist_mem u_mem (
        .clk_sys  (clk_sys),
        .we       (mem_we),
        .waddr    (mem_waddr),
        .wdata    (mem_wdata),
        .raddr    (mem_raddr),
        .rdata_ff (mem_rdata)
    );

    // ---------------- routed outputs ----------------
    // every output is registered, so table results lag one cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            f_ff   <= '0;
            cco_ff <= 1'b0;
        end
        else
        begin
            cco_ff <= chain[N_SLICE];
            for (int s = 0; s < N_SLICE; s++)
            begin
                if (ram_ff && s < 2)
                begin
                    f_ff[s] <= mem_f[2*s +: 2];
                end
                else if (ram_ff && s == 2)
                begin
                    f_ff[s] <= 2'b00;
                end
                else
                begin
                    f_ff[s] <= {f1_w[s], f0_w[s]};
                end
            end
        end
    end

    always_comb
    begin
        for (int s = 0; s < N_SLICE; s++)
        begin
            route_out[s].f0 = f_ff[s][0];
            route_out[s].f1 = f_ff[s][1];
            route_out[s].q  = q_ff[s];
        end
    end
endmodule

/* File: logic/slice_cell.sv */
`timescale 1ns/1ps
module slice_cell (
    // configuration
    input  wire tile_pkg::slice_cfg_t            cfg,
    input  wire logic [tile_pkg::LUT_W-1:0]     lut0,
    input  wire logic [tile_pkg::LUT_W-1:0]     lut1,
    // routing and state
    input  wire tile_pkg::slice_in_t             sin,
    input  wire logic [1:0]                      q,
    input  wire logic                            cin,
    // results
    output logic                                 f0,
    output logic                                 f1,
    output logic [1:0]                           d,
    output logic                                 cout
);
    import tile_pkg::*;

    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] g;
    logic [1:0] p;
    logic       c1;
    logic       l0;
    logic       l5;
    logic [2:0] sum;
    logic [2:0] dif;
    logic [2:0] res;
    logic [1:0] cnt;
    logic [2:0] trial;
    logic [3:0] prod;

    always_comb
    begin
        a     = {sin.t1[0], sin.t0[0]};
        b     = {sin.t1[1], sin.t0[1]};
        l0    = lut0[sin.t0];
        l5    = lut1[sin.t0];
        g     = a & b;
        p     = a ^ b;
        c1    = g[0] | (p[0] & cin);
        sum   = {1'b0, a} + {1'b0, b} + {2'b00, cin};
        dif   = {1'b0, a} + {1'b0, ~b} + {2'b00, cin};
        cnt   = sin.sel ? q - 2'h1 : q + 2'h1;
        trial = {q, sin.t0[2]} - {1'b0, b};
        prod  = {2'b00, a} * {2'b00, b};
        f0    = (cfg.lut5 && sin.sel) ? l5 : l0;
        f1    = lut1[sin.t1];
        cout  = 1'b0;
        res   = {1'b0, f1, f0};
        if (cfg.mode == MODE_RIPPLE)
        begin
            case (cfg.rop)
                OP_ADD:    res = sum;
                OP_SUB:    res = dif;
                OP_ADDSUB: res = sin.sel ? dif : sum;
                OP_UP:     res = {1'b0, q} + 3'h1;
                OP_DN:     res = {1'b0, q} - 3'h1;
                OP_UDCLR:  res = {1'b0, cnt};
                OP_UDLOAD: res = {1'b0, sin.t0[3] ? sin.direct : cnt};
                OP_CMP:    res = {a != b, a <= b, a >= b};
                OP_UDGE:   res = {a >= b, cnt};
                OP_UDLE:   res = {a <= b, cnt};
                OP_MULT:   res = {2'b00, a[0] & b[1]} + {2'b00, a[1] & b[0]} + {2'b00, cin};
                OP_SDIV:   res = trial[2] ? {1'b0, q[0], sin.t0[2]} : {1'b1, trial[1:0]};
                OP_SMUL1:  res = {q[1], {q[0], 1'b0} + (b[0] ? a : 2'h0)};
                OP_SMUL2:  res = {1'b0, prod[1:0] + (cin ? q : 2'h0)};
                OP_CARRY:  res = {g[1] | (p[1] & c1), p ^ {c1, cin}};
                default:   res = sum;
            endcase
            f0   = res[0];
            f1   = res[1];
            cout = res[2];
        end
        d = res[1:0];
    end
endmodule

/* File: logic/tile_pkg.sv */
package tile_pkg;
    localparam int N_SLICE   = 4;
    localparam int N_PAIR    = 2;
    localparam int N_LUT     = 8;
    localparam int LUT_W     = 16;
    localparam int ADDR_W    = 12;
    localparam int MEM_DEPTH = 16;
    localparam int MEM_AW    = 4;
    localparam int MEM_DW    = 4;

    // byte offsets on the register bus
    localparam logic [11:0] OFS_LUT  = 12'h000;
    localparam logic [11:0] OFS_CFG  = 12'h020;
    localparam logic [11:0] OFS_CTRL = 12'h030;
    localparam logic [11:0] OFS_STAT = 12'h034;
    localparam logic [11:0] OFS_MEM  = 12'h040;

    // control and status word bits
    localparam int CTRL_RUN = 0;
    localparam int CTRL_RAM = 1;
    localparam int CTRL_PDP = 2;
    localparam int STAT_RUN = 16;

    // reset values
    localparam logic [15:0] LUT_RST  = 16'h0000;
    localparam logic [2:0]  CTRL_RST = 3'h0;

    typedef enum logic [1:0] {MODE_LOGIC, MODE_RIPPLE, MODE_ROM} mode_t;

    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_ADDSUB, OP_UP, OP_DN, OP_UDCLR, OP_UDLOAD,
        OP_CMP, OP_UDGE, OP_UDLE, OP_MULT, OP_SDIV, OP_SMUL1, OP_SMUL2,
        OP_CARRY
    } rop_t;

    typedef struct packed {
        logic  init1;
        logic  init0;
        logic  async_sr;
        logic  neg_edge;
        logic  src1_direct;
        logic  src0_direct;
        logic  lut5;
        rop_t  rop;
        mode_t mode;
    } slice_cfg_t;

    localparam int CFG_W = $bits(slice_cfg_t);
    localparam logic [CFG_W-1:0] CFG_RST = '0;

    typedef struct packed {
        logic [3:0] t0;
        logic [3:0] t1;
        logic [1:0] direct;
        logic       sel;
    } slice_in_t;

    typedef struct packed {
        logic ce;
        logic local_set_clear;
        logic clk;
    } pair_ctl_t;

    typedef struct packed {
        logic       f0;
        logic       f1;
        logic [1:0] q;
    } slice_out_t;
endpackage

/* File: testbench/fabric_model.sv */
`timescale 1ns/1ps
module fabric_model (
    // system clock
    input  wire logic                                  clk_sys,
    // levels asked by the bench
    input  wire logic [1:0]                            clk_lvl,
    input  wire logic [1:0]                            ce,
    input  wire logic [1:0]                            set_clear,
    // pair controls toward the tile
    output tile_pkg::pair_ctl_t [tile_pkg::N_PAIR-1:0] pair_ctl
);
    import tile_pkg::*;
    // registered together so a slice clock edge and its enable arrive in one step
    always_ff @(posedge clk_sys)
    begin
        for (int p = 0; p < N_PAIR; p++)
        begin
            pair_ctl[p].clk <= clk_lvl[p];
            pair_ctl[p].ce  <= ce[p];
            pair_ctl[p].local_set_clear <= set_clear[p];
        end
    end
endmodule

/* File: testbench/logic_tile_assertions.sv */
`timescale 1ns/1ps
module logic_tile_assertions (
    // clock and reset
    input wire logic                                         clk_sys,
    input wire logic                                         rstn,
    // apb
    input wire logic                                         psel,
    input wire logic                                         penable,
    input wire logic                                         pwrite,
    input wire logic [tile_pkg::ADDR_W-1:0]                  paddr,
    input wire logic [31:0]                                  prdata,
    input wire logic                                         pready,
    input wire logic                                         pslverr,
    // fabric
    input wire tile_pkg::pair_ctl_t [tile_pkg::N_PAIR-1:0]   pair_ctl,
    input wire tile_pkg::slice_out_t [tile_pkg::N_SLICE-1:0] route_out,
    input wire logic                                         carry_chain_out
);
    import tile_pkg::*;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    // no apb traffic either, so a queued init reload cannot move q
    sequence s_pair0_quiet;
        !pair_ctl[0].ce && !pair_ctl[0].local_set_clear && !psel;
    endsequence
    AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("apb answer not in second access cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable && $past(penable))
        else $error("pready outside second access cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_STAT_READ_ONLY: assert property (pready && pwrite && paddr == OFS_STAT |-> pslverr)
        else $error("write to status not refused");
    AST_MISALIGNED: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    AST_UNMAPPED_ZERO: assert property (pready && !pwrite && paddr >= 12'h080 |-> pslverr && prdata == '0)
        else $error("unmapped read not refused with zero");
    AST_STAT_UPPER: assert property (pready && !pwrite && paddr == OFS_STAT |-> !pslverr && prdata[31:17] == '0)
        else $error("status read malformed");
    AST_HOLD_NO_ENABLE: assert property (s_pair0_quiet [*3] |-> $stable(route_out[0].q) && $stable(route_out[1].q))
        else $error("register moved with enable low");
    AST_RESET_QUIET: assert property (disable iff (1'b0) !rstn |=> route_out == '0 && !carry_chain_out && !pready)
        else $error("outputs not cleared by reset");
endmodule

/* File: testbench/logic_tile_bench.sv */
`timescale 1ns/1ps
module logic_tile_bench;
    import tile_pkg::*;
    logic                     clk_sys = 1'b0;
    logic                     rstn = 1'b0;
    logic                     psel = 1'b0;
    logic                     penable = 1'b0;
    logic                     pwrite = 1'b0;
    logic [ADDR_W-1:0]        paddr = '0;
    logic [31:0]              pwdata = '0;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    slice_in_t [N_SLICE-1:0]  route_in = '0;
    pair_ctl_t [N_PAIR-1:0]   pair_ctl;
    slice_out_t [N_SLICE-1:0] route_out;
    logic                     carry_chain_in = 1'b0;
    logic                     carry_chain_out;
    logic [1:0]               clk_lvl = '0;
    logic [1:0]               ce = '1;
    logic [1:0]               set_clear = '0;
    logic [31:0]              rd;
    logic                     err;
    int                       failures = 0;
    int                       compares = 0;
    int                       cycles = 0;

    always #2 clk_sys = ~clk_sys;

    logic_tile uut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .route_in(route_in), .pair_ctl(pair_ctl), .route_out(route_out),
        .carry_chain_in(carry_chain_in), .carry_chain_out(carry_chain_out));
    fabric_model fab (.clk_sys(clk_sys), .clk_lvl(clk_lvl), .ce(ce), .set_clear(set_clear),
        .pair_ctl(pair_ctl));

    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // request held until pready is seen at a rising edge; only the cycle timeout ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
        apb(1'b1, a, d);
        chk("write error flag", ee, err);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic ee, input string nm);
        apb(1'b0, a, '0);
        chk(nm, e, rd);
        chk("read error flag", ee, err);
    endtask

    task automatic edge_to(input logic [1:0] lvl);
        @(posedge clk_sys);
        clk_lvl <= lvl;
        settle(4);
    endtask

    function automatic logic [3:0] memq();
        return {route_out[1].f1, route_out[1].f0, route_out[0].f1, route_out[0].f0};
    endfunction

    task automatic t_apb;
        rc(OFS_CTRL, 32'h0, 1'b0, "ctrl reset");
        rc(OFS_STAT, 32'h0, 1'b0, "stat reset");
        rc(OFS_LUT, 32'h0, 1'b0, "lut reset");
        rc(12'h100, 32'h0, 1'b1, "unmapped");
        wr(12'h032, 32'h1, 1'b1);
        wr(OFS_STAT, 32'hff, 1'b1);
        rc(OFS_CTRL, 32'h0, 1'b0, "ctrl untouched");
    endtask

    task automatic t_logic;
        logic [15:0] p0;
        logic [15:0] p1;
        p0 = 16'h6996;
        p1 = 16'h00f1;
        wr(OFS_LUT, {16'h0, p0}, 1'b0);
        wr(OFS_LUT + 12'h4, {16'h0, p1}, 1'b0);
        wr(OFS_CTRL, 32'h1, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk_sys);
            route_in[0].t0 <= 4'(i);
            route_in[0].t1 <= 4'(15 - i);
            settle(2);
            chk("f0", p0[i], route_out[0].f0);
            chk("f1", p1[15 - i], route_out[0].f1);
        end
        wr(OFS_LUT, 32'h5, 1'b1);
        rc(OFS_LUT, {16'h0, p0}, 1'b0, "lut kept");
        wr(OFS_CTRL, 32'h0, 1'b0);
    endtask

    task automatic t_lut5;
        logic a;
        wr(OFS_LUT + 12'h8, 32'hffff, 1'b0);
        wr(OFS_LUT + 12'hc, 32'h0, 1'b0);
        wr(OFS_CFG + 12'h4, 32'h40, 1'b0);
        wr(OFS_CTRL, 32'h1, 1'b0);
        settle(2);
        a = route_out[1].f0;
        chk("f1 four input", 1'b0, route_out[1].f1);
        @(posedge clk_sys);
        route_in[1].sel <= 1'b1;
        settle(2);
        chk("five input select", 1'b1, a ^ route_out[1].f0);
        chk("f1 four input", 1'b0, route_out[1].f1);
        wr(OFS_CTRL, 32'h0, 1'b0);
    endtask

    task automatic t_cmp;
        logic [1:0] a;
        logic [1:0] b;
        wr(OFS_CFG + 12'hc, 32'h1d, 1'b0);
        wr(OFS_CFG, 32'h39, 1'b0);
        wr(OFS_CTRL, 32'h1, 1'b0);
        for (int k = 0; k < 16; k++)
        begin
            a = k[1:0];
            b = k[3:2];
            @(posedge clk_sys);
            route_in[3].t0 <= {2'b00, b[0], a[0]};
            route_in[3].t1 <= {2'b00, b[1], a[1]};
            route_in[0].t0 <= {2'b00, b[0], a[0]};
            route_in[0].t1 <= {2'b00, b[1], a[1]};
            carry_chain_in <= k[1] ^ k[2];
            settle(2);
            chk("carry sum", 2'(a + b + 2'(k[1] ^ k[2])), {route_out[0].f1, route_out[0].f0});
            chk("ge", a >= b, route_out[3].f0);
            chk("le", a <= b, route_out[3].f1);
            chk("ne", a != b, carry_chain_out);
        end
        wr(OFS_CTRL, 32'h0, 1'b0);
    endtask

    task automatic t_regs;
        wr(OFS_CFG, 32'h80, 1'b0);
        wr(OFS_CFG + 12'h8, 32'he80, 1'b0);
        wr(OFS_CTRL, 32'h1, 1'b0);
        settle(2);
        chk("init q slice0", 1'b0, route_out[0].q[0]);
        chk("init q slice2", 1'b1, route_out[2].q[0]);
        @(posedge clk_sys);
        route_in[0].direct <= 2'b01;
        edge_to(2'b11);
        chk("rise capture", 1'b1, route_out[0].q[0]);
        chk("rise ignored", 1'b1, route_out[2].q[0]);
        @(posedge clk_sys);
        route_in[0].direct <= 2'b00;
        edge_to(2'b00);
        chk("fall capture", 1'b0, route_out[2].q[0]);
        chk("fall ignored", 1'b1, route_out[0].q[0]);
        @(posedge clk_sys);
        ce <= 2'b00;
        route_in[2].direct <= 2'b01;
        edge_to(2'b11);
        edge_to(2'b00);
        chk("hold slice0", 1'b1, route_out[0].q[0]);
        chk("hold slice2", 1'b0, route_out[2].q[0]);
        @(posedge clk_sys);
        set_clear <= 2'b11;
        settle(4);
        chk("async set", 1'b1, route_out[2].q[0]);
        chk("sync waits", 1'b1, route_out[0].q[0]);
        @(posedge clk_sys);
        ce <= 2'b11;
        edge_to(2'b11);
        chk("sync clear", 1'b0, route_out[0].q[0]);
        @(posedge clk_sys);
        set_clear <= 2'b00;
        edge_to(2'b00);
        wr(OFS_CTRL, 32'h0, 1'b0);
    endtask

    task automatic t_ram;
        wr(OFS_MEM + 12'h14, 32'h9, 1'b0);
        wr(OFS_CTRL, 32'h3, 1'b0);
        @(posedge clk_sys);
        route_in[2].t0 <= 4'h5;
        settle(4);
        chk("ram init word", 4'h9, memq());
        chk("slice2 f", 2'b00, {route_out[2].f1, route_out[2].f0});
        @(posedge clk_sys);
        route_in[2].t0 <= 4'h3;
        route_in[2].direct <= 2'b01;
        route_in[1].direct <= 2'b01;
        route_in[0].direct <= 2'b10;
        edge_to(2'b01);
        @(posedge clk_sys);
        route_in[2].direct <= 2'b00;
        route_in[0].direct <= 2'b11;
        edge_to(2'b00);
        edge_to(2'b01);
        chk("ram write", 4'h6, memq());
        wr(OFS_CTRL, 32'h0, 1'b0);
        wr(OFS_CTRL, 32'h7, 1'b0);
        @(posedge clk_sys);
        route_in[0].t0 <= 4'h5;
        settle(4);
        chk("pdp read", 4'h9, memq());
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        t_apb();
        t_logic();
        t_lut5();
        t_cmp();
        t_regs();
        t_ram();
        final_report();
    end
endmodule

bind logic_tile logic_tile_assertions chk_i (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pair_ctl(pair_ctl), .route_out(route_out), .carry_chain_out(carry_chain_out));
